/* hw/osc_trim_pkg.sv */
package osc_trim_pkg;

  // Register offsets
  localparam logic [15:0] ADDR_FAST_CAL = 16'h000a;
  localparam logic [15:0] ADDR_LF_CTRL = 16'h000b;
  localparam logic [15:0] ADDR_SLOW_CAP = 16'h000c;
  localparam logic [15:0] ADDR_CNT_LO = 16'h0011;
  localparam logic [15:0] ADDR_CNT_HI = 16'h0012;
  localparam logic [15:0] ADDR_SLOT_GAP = 16'h0013;

  // Field positions and widths
  localparam int BIT_CAL_ENA = 10;
  localparam int BIT_ARM = 15;
  localparam int BIT_CAL_GO = 15;
  localparam int LF_TRIM_W = 10;
  localparam int SLOW_TRIM_W = 6;
  localparam int CAL_CNT_W = 15;
  localparam int LF_CNT_W = 8;

  // Reset values
  localparam logic [LF_TRIM_W-1:0] LF_TRIM_RST = 10'h2b2;
  localparam logic [SLOW_TRIM_W-1:0] SLOW_TRIM_RST = 6'h12;

  // Calibration windows in low-frequency cycles
  localparam int CAL_WIN_1M = 128;
  localparam int CAL_WIN_32K = 32;

  // Timebase for the capture counter
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

  // Synchroniser lanes
  localparam int SYNC_STAMP = 0;
  localparam int SYNC_FAST = 1;
  localparam int SYNC_LF = 2;
  localparam int SYNC_LANES = 3;

  typedef struct packed {
    logic [31:0] count;
    logic [15:0] gap;
  } capture_s;

  typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} cal_state_e;

endpackage

/* hw/pin_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_edge_sync needs WIDTH of at least 1");
  end

  // Three stages per lane; a change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_lane
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;
    assign agree = (s2_r == s3_r);
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        lvl_r <= 1'b0;
      end
      else
      begin
        s1_r <= pins_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (agree)
          lvl_r <= s3_r;
      end
    end
    assign level[i] = lvl_r;
    assign rise[i] = agree && s3_r && !lvl_r;
  end

endmodule
`default_nettype wire

/* hw/osc_trim_timestamp_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_trim_timestamp_capture
  import osc_trim_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic gp_pin_zero,
  input wire logic alt_stamp_in,
  input wire logic stamp_reassign,
  input wire logic [15:0] slot_gap_count,
  input wire logic fast_osc_in,
  input wire logic lf_osc_in,
  input wire logic lf_src_is_32k,
  output logic cal_clock_enable,
  output logic [LF_TRIM_W-1:0] lf_osc_freq_trim,
  output logic [SLOW_TRIM_W-1:0] slow_osc_trim
);

  if (TICK_DIV < 1 || TICK_DIV > 65536)
  begin : g_bad_tick
    $error("TICK_DIV must lie in 1 to 65536");
  end

  logic cal_ena_r;
  logic [LF_TRIM_W-1:0] lf_trim_r;
  logic [SLOW_TRIM_W-1:0] slow_trim_r;
  logic arm_r;
  logic arm_nxt;
  capture_s cap_r;
  logic [31:0] count_r;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic go_r;
  logic go_nxt;
  cal_state_e cal_state_r;
  cal_state_e cal_state_nxt;
  logic [LF_CNT_W-1:0] lf_cnt_r;
  logic [CAL_CNT_W-1:0] acc_r;
  logic [CAL_CNT_W-1:0] acc_nxt;
  logic [CAL_CNT_W-1:0] tally_r;
  logic [LF_CNT_W-1:0] win_last;
  logic cal_done;
  logic stamp_raw;
  logic capture_fire;
  logic [SYNC_LANES-1:0] rise;
  logic [SYNC_LANES-1:0] level;
  logic [15:0] rd_mux;

  // Address decode
  logic wr_lf;
  logic wr_slow;
  logic wr_fast;
  assign wr_lf = reg_write && (reg_addr == ADDR_LF_CTRL);
  assign wr_slow = reg_write && (reg_addr == ADDR_SLOW_CAP);
  assign wr_fast = reg_write && (reg_addr == ADDR_FAST_CAL);

  // Timestamp source select, then synchronise all pin inputs
  assign stamp_raw = stamp_reassign ? alt_stamp_in : gp_pin_zero;

  pin_edge_sync #(.WIDTH(SYNC_LANES)) u_sync (
    .clock(clock),
    .reset(reset),
    .pins_in({lf_osc_in, fast_osc_in, stamp_raw}),
    .level(level),
    .rise(rise)
  );

  // Free-running capture counter on a divided tick
  assign tick = (tick_cnt_r == 16'(TICK_DIV - 1));
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tick_cnt_r <= '0;
      count_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 16'h0001;
      if (tick)
        count_r <= count_r + 32'h0000_0001;
    end
  end

  // Capture arming; a software write wins over the self-clear
  assign capture_fire = arm_r && rise[SYNC_STAMP];
  assign arm_nxt = wr_slow ? reg_wdata[BIT_ARM] : (capture_fire ? 1'b0 : arm_r);

  // Trim, enable and arm registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cal_ena_r <= 1'b0;
      lf_trim_r <= LF_TRIM_RST;
      slow_trim_r <= SLOW_TRIM_RST;
      arm_r <= 1'b0;
    end
    else
    begin
      if (wr_lf)
      begin
        cal_ena_r <= reg_wdata[BIT_CAL_ENA];
        lf_trim_r <= reg_wdata[LF_TRIM_W-1:0];
      end
      if (wr_slow)
        slow_trim_r <= reg_wdata[SLOW_TRIM_W-1:0];
      arm_r <= arm_nxt;
    end
  end

  // Count and slot gap latched as one record
  always_ff @(posedge clock)
  begin
    if (reset)
      cap_r <= '0;
    else if (capture_fire)
      cap_r <= '{count: count_r, gap: slot_gap_count};
  end

  // Fast oscillator calibration; window opens at the first slow edge so it spans whole slow cycles
  assign win_last = lf_src_is_32k ? LF_CNT_W'(CAL_WIN_32K) : LF_CNT_W'(CAL_WIN_1M);
  assign acc_nxt = (rise[SYNC_FAST] && lf_cnt_r != '0 && acc_r != '1) ? acc_r + 1'b1 : acc_r;
  assign cal_done = (cal_state_r == CAL_RUN) && cal_ena_r && rise[SYNC_LF] && (lf_cnt_r == win_last);
  assign go_nxt = (wr_fast && reg_wdata[BIT_CAL_GO]) ? 1'b1 : (cal_done ? 1'b0 : go_r);

  // Calibration sequencing; dropping the enable abandons a cycle
  always_comb
  begin
    cal_state_nxt = cal_state_r;
    case (cal_state_r)
      CAL_IDLE:
        if (go_r && cal_ena_r)
          cal_state_nxt = CAL_RUN;
      CAL_RUN:
        if (!cal_ena_r || cal_done)
          cal_state_nxt = CAL_IDLE;
      default:
        cal_state_nxt = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cal_state_r <= CAL_IDLE;
      go_r <= 1'b0;
      lf_cnt_r <= '0;
      acc_r <= '0;
      tally_r <= '0;
    end
    else
    begin
      cal_state_r <= cal_state_nxt;
      go_r <= go_nxt;
      if (cal_state_r == CAL_IDLE)
      begin
        lf_cnt_r <= '0;
        acc_r <= '0;
      end
      else
      begin
        acc_r <= acc_nxt;
        if (rise[SYNC_LF])
          lf_cnt_r <= lf_cnt_r + 1'b1;
      end
      if (cal_done)
        tally_r <= acc_nxt;
    end
  end

  // Read data select; unmapped and reserved bits read zero
  assign rd_mux =
    (reg_addr == ADDR_FAST_CAL) ? {go_r, tally_r} :
    (reg_addr == ADDR_LF_CTRL) ? {5'h00, cal_ena_r, lf_trim_r} :
    (reg_addr == ADDR_SLOW_CAP) ? {arm_r, 9'h000, slow_trim_r} :
    (reg_addr == ADDR_CNT_LO) ? cap_r.count[15:0] :
    (reg_addr == ADDR_CNT_HI) ? cap_r.count[31:16] :
    (reg_addr == ADDR_SLOT_GAP) ? cap_r.gap : 16'h0000;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_read;
      if (reg_read)
        rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign cal_clock_enable = cal_ena_r;
  assign lf_osc_freq_trim = lf_trim_r;
  assign slow_osc_trim = slow_trim_r;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_cal_ena_write: assert property (wr_lf |=> cal_clock_enable == $past(reg_wdata[BIT_CAL_ENA]))
    else $error("calibration enable did not follow write");
  a_cal_off_idle: assert property (!cal_clock_enable |=> cal_state_r == CAL_IDLE)
    else $error("calibration ran while disabled");
  a_lf_trim_write: assert property (wr_lf |=> lf_osc_freq_trim == $past(reg_wdata[LF_TRIM_W-1:0]))
    else $error("low-frequency trim not stored");
  a_unarmed_hold: assert property (!arm_r |=> $stable(cap_r))
    else $error("capture changed while unarmed");
  a_arm_self_clear: assert property (capture_fire && !wr_slow |=> !arm_r)
    else $error("arm bit did not clear after capture");
  a_pin_zero_path: assert property ((!stamp_reassign && gp_pin_zero)[*4] |=> level[SYNC_STAMP])
    else $error("pin zero did not reach timestamp input");
  a_slow_trim_write: assert property (wr_slow |=> slow_osc_trim == $past(reg_wdata[SLOW_TRIM_W-1:0]))
    else $error("32 kHz trim not stored");
  a_count_hi_read: assert property (reg_read && reg_addr == ADDR_CNT_HI && !capture_fire
      |=> reg_rvalid && reg_rdata == cap_r.count[31:16])
    else $error("high count half read wrong");
  a_gap_capture: assert property (capture_fire |=> cap_r.gap == $past(slot_gap_count))
    else $error("slot gap not captured");
  a_cal_go_clear: assert property (cal_done && !(wr_fast && reg_wdata[BIT_CAL_GO])
      |=> !go_r && cal_state_r == CAL_IDLE && tally_r == $past(acc_nxt))
    else $error("calibration did not finish cleanly");
  a_pair_latch: assert property (capture_fire |=> cap_r.count == $past(count_r) && cap_r.gap == $past(slot_gap_count))
    else $error("capture pair inconsistent");

  c_capture: cover property (capture_fire);
  c_rearm_on_fire: cover property (capture_fire && wr_slow && reg_wdata[BIT_ARM]);
  c_cal_done: cover property (cal_done);
  c_gap_read: cover property (reg_read && reg_addr == ADDR_SLOT_GAP);

endmodule
`default_nettype wire

/* sim/stamp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module stamp_host (
  input wire logic clock,
  output logic pin_zero,
  output logic alt_pin
);
  // Both pins idle low
  initial
  begin
    pin_zero = 1'b0;
    alt_pin = 1'b0;
  end
  // One rising edge, held long enough for the pin filter
  task automatic pulse(input logic alt);
    @(negedge clock);
    if (alt)
      alt_pin = 1'b1;
    else
      pin_zero = 1'b1;
    repeat (5) @(negedge clock);
    alt_pin = 1'b0;
    pin_zero = 1'b0;
    repeat (5) @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* sim/osc_trim_timestamp_capture_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_trim_timestamp_capture_bench;
  import osc_trim_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  wire gp_pin_zero;
  wire alt_stamp_in;
  logic stamp_reassign = 1'b0;
  logic [15:0] slot_gap_count = 16'h0000;
  logic fast_osc_in = 1'b0;
  logic lf_osc_in = 1'b0;
  logic lf_src_is_32k = 1'b1;
  logic cal_clock_enable;
  logic [LF_TRIM_W-1:0] lf_osc_freq_trim;
  logic [SLOW_TRIM_W-1:0] slow_osc_trim;
  logic [7:0] tick = 8'h00;
  logic [15:0] rd;
  logic [15:0] lo1;
  int error_cnt = 0;
  int cmp_count = 0;

  osc_trim_timestamp_capture #(.TICK_DIV(2)) osc_trim_timestamp_capture_inst (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .gp_pin_zero(gp_pin_zero), .alt_stamp_in(alt_stamp_in),
    .stamp_reassign(stamp_reassign), .slot_gap_count(slot_gap_count), .fast_osc_in(fast_osc_in),
    .lf_osc_in(lf_osc_in), .lf_src_is_32k(lf_src_is_32k), .cal_clock_enable(cal_clock_enable),
    .lf_osc_freq_trim(lf_osc_freq_trim), .slow_osc_trim(slow_osc_trim));
  stamp_host stamp_host_inst (.clock(clock), .pin_zero(gp_pin_zero), .alt_pin(alt_stamp_in));

  // Clock and oscillator stand-ins: fast period 8 cycles, slow 128
  always #5 clock = ~clock;
  always @(negedge clock)
  begin
    tick <= tick + 8'h01;
    fast_osc_in <= tick[2];
    lf_osc_in <= tick[6];
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  // Read answer stands from the edge that takes the strobe until the next edge
  task automatic rdr(input logic [15:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    check({15'h0, reg_rvalid}, 16'h0001);
    rd = reg_rdata;
  endtask

  task automatic t_reset;
    rdr(ADDR_LF_CTRL);
    check(rd, 16'h02b2);
    check({15'h0, cal_clock_enable}, 16'h0000);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h0012);
    for (int i = 0; i < 3; i++)
    begin
      rdr(ADDR_CNT_LO + 16'(i));
      check(rd, 16'h0000);
    end
  endtask
  task automatic t_trim;
    wr(ADDR_LF_CTRL, 16'h07ff);
    check({15'h0, cal_clock_enable}, 16'h0001);
    check({6'h0, lf_osc_freq_trim}, 16'h03ff);
    wr(ADDR_SLOW_CAP, 16'h7fff);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h003f);
    check({10'h0, slow_osc_trim}, 16'h003f);
    wr(ADDR_SLOW_CAP, 16'h0012);
    wr(ADDR_LF_CTRL, 16'h0000);
    check({6'h0, lf_osc_freq_trim}, 16'h0000);
    wr(ADDR_CNT_HI, 16'hffff);
    rdr(ADDR_CNT_HI);
    check(rd, 16'h0000);
    rdr(16'h0020);
    check(rd, 16'h0000);
  endtask
  task automatic t_capture;
    slot_gap_count = 16'h1234;
    stamp_host_inst.pulse(1'b0);
    rdr(ADDR_CNT_LO);
    check(rd, 16'h0000);
    wr(ADDR_SLOW_CAP, 16'h8012);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h8012);
    stamp_host_inst.pulse(1'b0);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h0012);
    rdr(ADDR_SLOT_GAP);
    check(rd, 16'h1234);
    rdr(ADDR_CNT_LO);
    lo1 = rd;
    check({15'h0, lo1 != 16'h0}, 16'h0001);
  endtask
  task automatic t_reassign;
    slot_gap_count = 16'hbeef;
    stamp_reassign = 1'b1;
    wr(ADDR_SLOW_CAP, 16'h8012);
    stamp_host_inst.pulse(1'b0);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h8012);
    stamp_host_inst.pulse(1'b1);
    rdr(ADDR_SLOW_CAP);
    check(rd, 16'h0012);
    rdr(ADDR_SLOT_GAP);
    check(rd, 16'hbeef);
    rdr(ADDR_CNT_LO);
    check({15'h0, rd > lo1}, 16'h0001);
    stamp_reassign = 1'b0;
  endtask
  // 32 slow cycles of 128 clocks hold about 512 fast edges, 128 of them about 2048
  task automatic t_cal;
    wr(ADDR_FAST_CAL, 16'h8000);
    repeat (600) @(negedge clock);
    rdr(ADDR_FAST_CAL);
    check({15'h0, rd[15]}, 16'h0001);
    wr(ADDR_LF_CTRL, 16'h0400);
    for (int i = 0; i < 3000 && rd[15]; i++)
      rdr(ADDR_FAST_CAL);
    check({15'h0, rd[15]}, 16'h0000);
    check({15'h0, rd[14:0] >= 15'd508 && rd[14:0] <= 15'd516}, 16'h0001);
    lf_src_is_32k = 1'b0;
    wr(ADDR_FAST_CAL, 16'h8000);
    rdr(ADDR_FAST_CAL);
    for (int i = 0; i < 10000 && rd[15]; i++)
      rdr(ADDR_FAST_CAL);
    check({15'h0, rd[15]}, 16'h0000);
    check({15'h0, rd[14:0] >= 15'd2044 && rd[14:0] <= 15'd2052}, 16'h0001);
    lf_src_is_32k = 1'b1;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_trim();
    t_capture();
    t_reassign();
    t_cal();
    results();
  end
  // Watchdog
  initial
  begin
    #400us;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
